/* logic/aisc_defines.svh */
// Constants for the analog-input scan acquisition controller
`ifndef AISC_DEFINES_SVH
`define AISC_DEFINES_SVH
`define AISC_CH_W 4
`define AISC_RANGE_W 2
`define AISC_DIFF_OFFSET 4'h8
`define AISC_DATA_W 16
`define AISC_OUT_DEPTH 2'h2
`define AISC_SYNC_RESET 2'h0
`endif

/* logic/aisc_pkg.sv */
// Types for the analog-input scan acquisition controller
`include "aisc_defines.svh"
package aisc_pkg;
	// Ground-reference selection per scan entry
	typedef enum logic [1:0] {
		AISC_TERM_RSE = 2'h0,
		AISC_TERM_NRSE = 2'h1,
		AISC_TERM_DIFF = 2'h2
	} aisc_term_t;

	// One scan-list entry
	typedef struct packed {
		logic [`AISC_CH_W-1:0] channel;
		logic [`AISC_RANGE_W-1:0] range;
		aisc_term_t term;
	} aisc_entry_t;

	// Settings sent to the input mux and amplifier
	typedef struct packed {
		logic [`AISC_CH_W-1:0] pos_ch;
		logic [`AISC_CH_W-1:0] neg_ch;
		logic neg_is_gnd;
		logic neg_is_sense;
		logic [`AISC_RANGE_W-1:0] range;
	} aisc_mux_t;

	// Sample word towards the host stream
	typedef struct packed {
		logic [`AISC_DATA_W-1:0] code;
		logic [`AISC_CH_W-1:0] channel;
	} aisc_sample_t;

	typedef enum logic [3:0] {
		AISC_IDLE = 4'h1,
		AISC_ARMED = 4'h2,
		AISC_RUN = 4'h4,
		AISC_CONV = 4'h8
	} aisc_state_t;
endpackage

/* logic/aisc_ctrl.sv */
// Analog-input scan acquisition controller with sample buffering
//
// Contract
// - One software command yields exactly one conversion; it is accepted only in idle.
// - Hardware timing paced by internal or external sample clock.
// - Hardware-timed acquisition may start on a hardware trigger.
// - Timed samples go through a buffer and stream out as blocks.
// - Finite mode stops after the programmed sample total.
// - Continuous mode runs until host stop request; an overflow error also ends it.
// - Buffer overflow raises a reported error.
// - No hardware-timed single point; timed runs are finite or continuous.
// - Scan list in any order; each entry applies its own range.
// - Each entry carries its own terminal configuration.
// - Differential: input n positive, n plus 8 negative.
`timescale 1ns/100ps
`include "aisc_defines.svh"
module aisc_ctrl #(
	parameter int SCAN_DEPTH = 16,
	parameter int COUNT_W = 32,
	parameter int FIFO_DEPTH = 64,
	parameter int BLOCK_W = 8
) (
	input wire logic clock, // 200 MHz system clock
	input wire logic rst_b, // Async reset, active low
	input wire logic sw_conv_cmd, // One-cycle software conversion command
	input wire logic hw_start, // Start a hardware-timed run
	input wire logic hw_stop, // Host stop request
	input wire logic continuous, // 1 continuous, 0 finite
	input wire logic use_trigger, // Wait for trigger before sampling
	input wire logic ext_clk_sel, // 1 external sample clock
	input wire logic ext_sample_clk, // External sample clock pin
	input wire logic ext_trigger, // External start trigger pin
	input wire logic [COUNT_W-1:0] int_clk_div, // Internal clock period in cycles
	input wire logic [COUNT_W-1:0] sample_total, // Finite sample total
	input wire logic [$clog2(SCAN_DEPTH)-1:0] scan_len_m1, // Scan entries minus one
	input wire logic scan_wr, // Scan-list write strobe
	input wire logic [$clog2(SCAN_DEPTH)-1:0] scan_wr_idx, // Scan-list write index
	input wire aisc_pkg::aisc_entry_t scan_wr_entry, // Scan-list write data
	input wire logic err_clear, // Clear sticky overflow error
	output aisc_pkg::aisc_mux_t mux_cfg, // Mux and amplifier setting
	output logic adc_start, // Start one conversion
	input wire logic adc_done, // Conversion finished
	input wire logic [`AISC_DATA_W-1:0] adc_code, // Conversion result
	output aisc_pkg::aisc_sample_t sw_data, // Software-timed result
	output logic sw_valid, // Software result valid pulse
	output aisc_pkg::aisc_sample_t st_data, // Stream data word
	output logic st_valid, // Stream word valid
	input wire logic st_ready, // Stream sink ready
	output logic st_block_end, // Last word of a block
	output logic busy, // Hardware run active
	output logic overflow_err // Sticky overflow error
);
	import aisc_pkg::*;
	// Pointer and index widths follow the depth parameters
	localparam int AW = $clog2(FIFO_DEPTH);
	localparam int SW = $clog2(SCAN_DEPTH);

	// Scan list storage, written by host, read during scans
	aisc_entry_t scan_mem [SCAN_DEPTH];

	// Sample buffer array
	aisc_sample_t fifo_mem [FIFO_DEPTH];

	// Controller state apart from the two memories; one comb process fills the copy, one flop bank holds it
	typedef struct packed {
		aisc_state_t state;
		logic stop_req; // Stop seen during a run, kept until idle
		logic [1:0] ext_clk_s;
		logic [1:0] ext_trg_s;
		logic ext_clk_q;
		logic [COUNT_W-1:0] div_cnt;
		logic [COUNT_W-1:0] done_cnt;
		logic [SW-1:0] idx;
		logic sw_conv;
		logic err;
		aisc_mux_t mux;
		logic adc_start;
		aisc_sample_t sw_data;
		logic sw_valid;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] level;
		aisc_sample_t out0;
		aisc_sample_t out1;
		logic [1:0] out_cnt;
		logic [BLOCK_W-1:0] blk_cnt0;
		logic [BLOCK_W-1:0] blk_cnt1;
		logic [BLOCK_W-1:0] blk_cnt;
	} aisc_ctrl_state_t;

	// Registered state and its next value
	aisc_ctrl_state_t cur;
	aisc_ctrl_state_t next_cur;

	// Helper terms shared by the next-state logic
	aisc_entry_t entry;
	logic tick;
	logic ext_rise;
	logic fifo_push;
	logic fifo_pop;
	logic out_pop;
	logic fifo_full;
	logic fifo_empty;
	logic hw_done;
	logic stop_now;

	// Scan entry at the current index drives the mux one cycle later
	assign entry = scan_mem[cur.idx];

	// Scan-list writes; a write during a run takes effect at once
	always_ff @(posedge clock) begin
		if (scan_wr) begin
			scan_mem[scan_wr_idx] <= scan_wr_entry;
		end
	end

	// Buffer writes; memory needs no reset
	always_ff @(posedge clock) begin
		if (fifo_push) begin
			fifo_mem[cur.wr_ptr] <= '{code: adc_code, channel: cur.mux.pos_ch};
		end
	end

	// Sample tick from the chosen source; sync stage 1 is read only by stage 2
	assign ext_rise = cur.ext_clk_s[1] & ~cur.ext_clk_q;
	assign tick = ext_clk_sel ? ext_rise : (cur.div_cnt == '0);

	// Buffer fill flags; level counts up to the full depth, so it has one extra bit
	assign fifo_full = cur.level == (AW+1)'(FIFO_DEPTH);
	assign fifo_empty = cur.level == '0;

	// End of a hardware-timed conversion
	assign hw_done = adc_done && cur.state == AISC_CONV && !cur.sw_conv;

	// A stop held on the pin or latched earlier ends the run
	assign stop_now = hw_stop || cur.stop_req;

	// Timed conversion result goes into the buffer unless in error or the buffer is full
	assign fifo_push = hw_done && !cur.err && !fifo_full;

	// Refill the output stage whenever it has a free slot
	assign fifo_pop = !fifo_empty && cur.out_cnt < `AISC_OUT_DEPTH;

	// Word leaves when the sink takes it
	assign out_pop = st_valid && st_ready;

	// Next-state logic
	always_comb begin
		next_cur = cur;
		// Two-stage synchronisers for the pins, then the edge history bit
		next_cur.ext_clk_s = {cur.ext_clk_s[0], ext_sample_clk};
		next_cur.ext_trg_s = {cur.ext_trg_s[0], ext_trigger};
		next_cur.ext_clk_q = cur.ext_clk_s[1];
		// Pulses last one cycle unless set again below
		next_cur.adc_start = 1'b0;
		next_cur.sw_valid = 1'b0;
		// Internal divider reloads so the period is int_clk_div cycles
		// A divide value of zero acts as the largest count, so keep it at one or more
		if (cur.div_cnt == '0 || cur.state == AISC_IDLE) begin
			next_cur.div_cnt = int_clk_div - COUNT_W'(1);
		end else begin
			next_cur.div_cnt = cur.div_cnt - COUNT_W'(1);
		end
		// Overflow: set wins over clear so no event is lost
		if (err_clear) begin
			next_cur.err = 1'b0;
		end
		// A full buffer cannot take the word: drop it and flag the loss
		if (hw_done && fifo_full) begin
			next_cur.err = 1'b1;
		end
		// Latch a stop so a short request during a conversion is not missed
		if (hw_stop && cur.state != AISC_IDLE) begin
			next_cur.stop_req = 1'b1;
		end
		// Sequencer: idle, waiting for trigger, waiting for a tick, converting
		unique case (cur.state)
			AISC_IDLE: begin
				next_cur.idx = '0;
				next_cur.done_cnt = '0;
				next_cur.stop_req = 1'b0;
				if (sw_conv_cmd) begin
					// Single on-demand conversion of the first entry
					next_cur.sw_conv = 1'b1;
					next_cur.adc_start = 1'b1;
					next_cur.state = AISC_CONV;
				end else if (hw_start && !cur.err) begin
					// Only buffered runs exist: finite or continuous
					next_cur.sw_conv = 1'b0;
					next_cur.state = use_trigger ? AISC_ARMED : AISC_RUN;
				end
			end
			AISC_ARMED: begin
				if (stop_now) begin
					next_cur.state = AISC_IDLE;
				// Trigger level after synchronising releases the run
				end else if (cur.ext_trg_s[1]) begin
					next_cur.state = AISC_RUN;
				end
			end
			AISC_RUN: begin
				if (stop_now || cur.err) begin
					next_cur.state = AISC_IDLE;
				end else if (!continuous && cur.done_cnt >= sample_total) begin
					next_cur.state = AISC_IDLE;
				end else if (tick) begin
					next_cur.adc_start = 1'b1;
					next_cur.state = AISC_CONV;
				end
			end
			AISC_CONV: begin
				if (adc_done) begin
					if (cur.sw_conv) begin
						// Result goes straight to the software register, not the buffer
						next_cur.sw_data = '{code: adc_code, channel: cur.mux.pos_ch};
						next_cur.sw_valid = 1'b1;
						next_cur.state = AISC_IDLE;
					end else begin
						next_cur.done_cnt = cur.done_cnt + COUNT_W'(1);
						// Step and wrap the scan list
						next_cur.idx = (cur.idx == scan_len_m1) ? '0 : cur.idx + SW'(1);
						next_cur.state = (stop_now || next_cur.err) ? AISC_IDLE : AISC_RUN;
					end
				end
			end
			default: begin
				next_cur.state = AISC_IDLE;
			end
		endcase
		// Mux follows the current entry
		next_cur.mux.range = entry.range;
		next_cur.mux.pos_ch = entry.channel;
		next_cur.mux.neg_ch = '0;
		next_cur.mux.neg_is_gnd = entry.term == AISC_TERM_RSE;
		next_cur.mux.neg_is_sense = entry.term == AISC_TERM_NRSE;
		if (entry.term == AISC_TERM_DIFF) begin
			// Only the low half may be a differential positive input
			next_cur.mux.pos_ch = {1'b0, entry.channel[`AISC_CH_W-2:0]};
			next_cur.mux.neg_ch = {1'b0, entry.channel[`AISC_CH_W-2:0]}
				+ `AISC_DIFF_OFFSET;
		end
		// Buffer pointers
		if (fifo_push) begin
			next_cur.wr_ptr = cur.wr_ptr + AW'(1);
		end
		if (fifo_pop) begin
			next_cur.rd_ptr = cur.rd_ptr + AW'(1);
		end
		// Level moves by push minus pop; both may happen in one cycle
		next_cur.level = cur.level + (AW+1)'(fifo_push) - (AW+1)'(fifo_pop);
		// Two-entry output stage: receiver stall loses nothing
		if (out_pop) begin
			next_cur.out0 = cur.out1;
			next_cur.blk_cnt0 = cur.blk_cnt1;
			next_cur.out_cnt = cur.out_cnt - 2'h1;
		end
		// A popped word fills the first free slot of the stage
		if (fifo_pop) begin
			next_cur.blk_cnt = cur.blk_cnt + BLOCK_W'(1);
			if (next_cur.out_cnt == 2'h0) begin
				next_cur.out0 = fifo_mem[cur.rd_ptr];
				next_cur.blk_cnt0 = cur.blk_cnt;
			end else begin
				next_cur.out1 = fifo_mem[cur.rd_ptr];
				next_cur.blk_cnt1 = cur.blk_cnt;
			end
			next_cur.out_cnt = next_cur.out_cnt + 2'h1;
		end
	end

	// State register
	// Synchronisers reset to the idle pin level so no false edge follows reset
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cur <= '0;
			cur.state <= AISC_IDLE;
			cur.ext_clk_s <= `AISC_SYNC_RESET;
			cur.ext_trg_s <= `AISC_SYNC_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	// Converter side: mux setting and start pulse straight from flops
	assign mux_cfg = cur.mux;
	assign adc_start = cur.adc_start;

	// Software-timed result
	assign sw_data = cur.sw_data;
	assign sw_valid = cur.sw_valid;

	// Stream side; valid is the only combinational handshake term
	assign st_data = cur.out0;
	assign st_valid = cur.out_cnt != 2'h0;
	// Held count of an emptied stage is stale, so the flag is gated by valid
	assign st_block_end = st_valid && cur.blk_cnt0 == '1;

	// Run status; a software conversion never counts as a timed run
	assign busy = cur.state != AISC_IDLE && !cur.sw_conv;
	assign overflow_err = cur.err;
endmodule

/* dv/aisc_ctrl_sva.sv */
// Assertion checker for the scan acquisition controller
`timescale 1ns/100ps
module aisc_ctrl_chk (
	input wire logic clock, // Clock
	input wire logic rst_b, // Reset, active low
	input wire logic hw_start, // Run start
	input wire logic adc_done, // Conversion done
	input wire aisc_pkg::aisc_mux_t mux_cfg, // Mux setting
	input wire logic adc_start, // Conversion start
	input wire logic sw_valid, // Software result
	input wire aisc_pkg::aisc_sample_t st_data, // Stream word
	input wire logic st_valid, // Stream valid
	input wire logic st_ready, // Stream ready
	input wire logic st_block_end, // Block end
	input wire logic busy, // Run active
	input wire logic err_clear, // Error clear
	input wire logic overflow_err // Sticky error
);
	import aisc_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// Mux is still zero just after reset, so diff check waits two edges
	chk_start_pulse: assert property (adc_start |=> !adc_start) else $error("start too long");
	chk_sw_answer: assert property (sw_valid |-> $past(adc_done) && !busy) else $error("bad sw valid");
	chk_err_sticky: assert property (overflow_err && !err_clear |=> overflow_err) else $error("lost err");
	chk_err_halts: assert property (overflow_err |=> !busy) else $error("run despite err");
	chk_diff_pair: assert property ($past(rst_b, 2) && !mux_cfg.neg_is_gnd && !mux_cfg.neg_is_sense
		|-> !mux_cfg.pos_ch[3] && mux_cfg.neg_ch == mux_cfg.pos_ch + 4'h8) else $error("bad pair");
	chk_stream_hold: assert property (st_valid && !st_ready |=> st_valid && $stable(st_data))
		else $error("word lost");
	chk_run_cause: assert property ($rose(busy) |-> $past(hw_start) && !$past(overflow_err))
		else $error("bad run start");
	chk_block_valid: assert property (st_block_end |-> st_valid) else $error("stray block end");
	cover property (sw_valid);
	cover property (st_valid && st_ready && st_block_end);
	cover property ($rose(overflow_err));
endmodule
bind aisc_ctrl aisc_ctrl_chk chk_u (.clock, .rst_b, .hw_start, .adc_done, .mux_cfg, .adc_start,
	.sw_valid, .st_data, .st_valid, .st_ready, .st_block_end, .busy, .err_clear, .overflow_err);

/* dv/aisc_host_model.sv */
// Host-side stream sink with random stalls
`timescale 1ns/100ps
module aisc_host_model (
	input wire logic clock, // Clock
	input wire logic stall, // Hold off the stream
	output logic st_ready // Sink ready
);
	// Random ready; a slow host is what provokes overflow
	initial begin
		st_ready = 1'b0;
		forever begin
			@(negedge clock);
			st_ready = !stall && $urandom_range(1);
		end
	end
endmodule

/* dv/aisc_ctrl_bench.sv */
// Self-checking bench for the scan acquisition controller
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
	$display("unexpected %s exp %h seen %h", nm, e, a); end end
module aisc_ctrl_bench;
	import aisc_pkg::*;
	logic clock, rst_b, sw_conv_cmd, hw_start, hw_stop, continuous, use_trigger, ext_clk_sel;
	logic ext_sample_clk, ext_trigger, scan_wr, err_clear, adc_start, adc_done, sw_valid;
	logic st_valid, st_ready, st_block_end, busy, overflow_err, stall, hw_mode, chk_en, blk_chk;
	logic [31:0] int_clk_div, sample_total;
	logic [3:0] scan_len_m1, scan_wr_idx, exp_idx;
	logic [15:0] adc_code;
	aisc_entry_t scan_wr_entry;
	aisc_entry_t list [3];
	aisc_mux_t mux_cfg;
	aisc_sample_t sw_data, st_data;
	aisc_sample_t sw_q[$], st_q[$];
	int n_mismatch, n_compared, n_starts, n_words;
	aisc_ctrl #(.FIFO_DEPTH(4), .BLOCK_W(2)) dut_u (.clock, .rst_b, .sw_conv_cmd, .hw_start,
		.hw_stop, .continuous, .use_trigger, .ext_clk_sel, .ext_sample_clk, .ext_trigger,
		.int_clk_div, .sample_total, .scan_len_m1, .scan_wr, .scan_wr_idx, .scan_wr_entry,
		.err_clear, .mux_cfg, .adc_start, .adc_done, .adc_code, .sw_data, .sw_valid, .st_data,
		.st_valid, .st_ready, .st_block_end, .busy, .overflow_err);
	aisc_host_model host_u (.clock, .stall, .st_ready);
	initial begin
		clock = 0;
		forever #2.5 clock = ~clock;
	end
	task automatic tick(int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		tick(1);
		s = 0;
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Bounded wait for run end and an empty note queue
	task automatic wait_idle();
		int k;
		for (k = 0; k < 2000 && (busy !== 1'b0 || st_q.size() > 0); k++) tick(1);
		if (k == 2000) `CHK("idle wait", 1'b0, 1'b1)
	endtask
	// Converter model: answers three cycles after a start and notes the word
	always @(posedge clock) begin
		if (adc_start) begin
			n_starts++;
			tick(3);
			adc_code = 16'($urandom);
			adc_done = 1;
			if (!hw_mode) sw_q.push_back({adc_code, list[0].channel});
			else if (chk_en) begin
				st_q.push_back({adc_code, list[exp_idx].channel});
				exp_idx = (exp_idx == scan_len_m1) ? 4'h0 : exp_idx + 4'h1;
			end
			tick(1);
			adc_done = 0;
		end
	end
	// Watcher: oldest note against each result
	always @(posedge clock) begin
		aisc_sample_t ex;
		if (sw_valid) begin
			ex = sw_q.pop_front();
			`CHK("sw_data", ex, sw_data)
		end
		if (st_valid && st_ready && chk_en) begin
			n_words++;
			ex = st_q.pop_front();
			`CHK("st_data", ex, st_data)
			if (blk_chk) `CHK("block_end", n_words % 4 == 0, st_block_end)
		end
	end
	// Watchdog well beyond the few hundred cycles needed
	initial begin
		#100us;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'h090b8011));
		{rst_b, sw_conv_cmd, hw_start, hw_stop, continuous, use_trigger, ext_clk_sel} = 0;
		{ext_sample_clk, ext_trigger, scan_wr, err_clear, adc_done, adc_code, stall, hw_mode} = 0;
		{int_clk_div, sample_total, scan_wr_idx, scan_wr_entry, exp_idx} = 0;
		scan_len_m1 = 4'h2;
		chk_en = 1;
		blk_chk = 0;
		list = '{'{4'h5, 2'h1, AISC_TERM_DIFF}, '{4'h2, 2'h3, AISC_TERM_RSE},
			'{4'h9, 2'h0, AISC_TERM_NRSE}};
		repeat (6) @(posedge clock);
		tick(1);
		rst_b = 1;
		// Channels out of order, each with its own range and terminal
		scan_wr = 1;
		foreach (list[i]) begin
			scan_wr_idx = 4'(i);
			scan_wr_entry = list[i];
			tick(1);
		end
		scan_wr = 0;
		tick(2);
		`CHK("mux_cfg", 12'h5d1, mux_cfg)
		repeat (3) begin
			pulse(sw_conv_cmd);
			tick(8);
		end
		`CHK("sw convs", 3, n_starts)
		// Finite run on the internal divider
		{int_clk_div, sample_total, hw_mode, blk_chk, n_starts} = {32'h4, 32'h6, 2'h3, 32'h0};
		pulse(hw_start);
		wait_idle();
		`CHK("finite count", 6, n_starts)
		// Continuous run, external clock, gated by trigger
		{blk_chk, exp_idx, n_starts} = 0;
		{continuous, use_trigger, ext_clk_sel} = 3'h7;
		pulse(hw_start);
		repeat (4) begin tick(10); ext_sample_clk = ~ext_sample_clk; end
		`CHK("no trigger", 0, n_starts)
		ext_trigger = 1;
		repeat (20) begin tick(10); ext_sample_clk = ~ext_sample_clk; end
		tick(15);
		`CHK("ext paced", 10, n_starts)
		`CHK("still running", 1'b1, busy)
		hw_stop = 1;
		tick(3);
		{hw_stop, ext_trigger} = 0;
		wait_idle();
		// Stalled host forces overflow; words then go unchecked
		{chk_en, use_trigger, ext_clk_sel, stall, int_clk_div} = {4'h1, 32'h2};
		pulse(hw_start);
		for (int k = 0; k < 300 && !overflow_err; k++) tick(1);
		tick(1);
		`CHK("overflow", 2'h2, {overflow_err, busy})
		pulse(hw_start);
		tick(2);
		`CHK("refused start", 1'b0, busy)
		pulse(err_clear);
		`CHK("err cleared", 1'b0, overflow_err)
		stall = 0;
		tick(40);
		end_of_test();
	end
endmodule
